// >>> core/trc_defines.svh
// Constants for the reload, clock select and output block of the third timer.
// Assumes an 8-bit special-function-register bus clocked by clk_sys.
//
// Overview of operation
// - On each overflow the reload pair is loaded into the timer count.
// - Config bit 5 picks count source: preceding-timer overflow or prescaled clock.
// - Prescaler codes 0 to 14 divide by two to the code; 15 equals 14.
// - Config bit 4 gates the timer output onto the mapped pin.
// - Default mode: one clock pulse on the output per overflow.
// - Toggle select bit set: output level inverts on each overflow.
// - Mapping bit 2 swaps the count, trigger and output pin set.
// - Three timers may cascade, each overflow clocking the next.
// - Cascading leaves capture, reload and output working unchanged.
// - Cascade stays usable with the pulse width measurement units.
// - Trigger falling edge captures count or loads reload value, per select.
// - Overflow is a step from FFFF counting up, from 0000 counting down.
`ifndef TRC_DEFINES_SVH
`define TRC_DEFINES_SVH

// ****************************************************************
// Register addresses
// ****************************************************************
`define TRC_ADDR_RCAP_LOW 8'h96
`define TRC_ADDR_RCAP_HIGH 8'h97
`define TRC_ADDR_CLK_CFG 8'h9D
`define TRC_ADDR_IO_MAP 8'hE1

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define TRC_CFG_SRC_BIT 5
`define TRC_CFG_OUTEN_BIT 4
`define TRC_CFG_WR_MASK 8'h3F
`define TRC_MAP_BIT 2
`define TRC_RESET_BYTE 8'h00
`define TRC_RESET_WORD 16'h0000
`define TRC_COUNT_MAX 16'hFFFF
`define TRC_PRESC_MAX_CODE 4'hE
`define TRC_PRESC_ONES 14'h3FFF

`endif

// >>> core/trc_pkg.sv
// Types shared by the third timer block.
// Assumes nothing beyond the defines header.
package trc_pkg;
    typedef logic [7:0] trc_byte_t;
    typedef logic [15:0] trc_word_t;
endpackage

// >>> core/trc_prescaler.sv
// Power-of-two prescaler giving a one-cycle tick.
// Assumes the code is stable or its change may shorten one period.
`include "trc_defines.svh"
module trc_prescaler
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [3:0] code,
    output logic tick
);
    import trc_pkg::*;
    logic [13:0] cnt_r;
    logic [13:0] cnt_nxt;
    logic [13:0] mask;
    logic [3:0] eff;

    // Clamp code 15 to code 14, build terminal mask
    always_comb
    begin
        eff = (code > `TRC_PRESC_MAX_CODE) ? `TRC_PRESC_MAX_CODE : code;
        mask = 14'(~(`TRC_PRESC_ONES << eff));
        tick = ((cnt_r & mask) == mask);
        cnt_nxt = tick ? 14'h0000 : 14'(cnt_r + 14'h0001);
    end

    // Counter register
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            cnt_r <= 14'h0000;
        else
            cnt_r <= cnt_nxt;
    end

    // Code 0 ticks every cycle
    property p_div1;
        @(posedge clk_sys) disable iff (rst) (code == 4'h0) |-> tick;
    endproperty
    a_div1: assert property (p_div1) else $error("div by one not ticking");

    // Code 1 never ticks twice in a row
    property p_div2;
        @(posedge clk_sys) disable iff (rst)
            (code == 4'h1 && $stable(code) && tick) |=> !tick;
    endproperty
    a_div2: assert property (p_div2) else $error("div by two ticks twice");
endmodule // trc_prescaler

// >>> core/trc_timer2.sv
// Third timer: reload/capture pair, clock select, output driver, pin map.
// Assumes the register bus gives a one-cycle write strobe and a read address
// and the pins are synchronous to clk_sys.
`include "trc_defines.svh"
module trc_timer2
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    output trc_pkg::trc_byte_t sfr_rdata,
    input wire logic run_enable,
    input wire logic count_down,
    input wire logic counter_mode,
    input wire logic toggle_output_select,
    input wire logic external_trigger_enable,
    input wire logic reload_or_capture_select,
    input wire logic prev_timer_overflow,
    input wire logic pin_p10_in,
    input wire logic pin_p11_in,
    input wire logic pin_p61_in,
    input wire logic pin_p60_in,
    output logic pin_p44_out,
    output logic pin_p44_oe,
    output logic pin_p12_out,
    output logic pin_p12_oe,
    output trc_pkg::trc_word_t count_value,
    output logic overflow_pulse,
    output logic trigger_event
);
    import trc_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    trc_word_t count_r, count_nxt;
    trc_byte_t rcap_lo_r, rcap_lo_nxt, rcap_hi_r, rcap_hi_nxt;
    logic [5:0] cfg_r, cfg_nxt;
    logic map_r, map_nxt;
    logic out_r, out_nxt;
    logic cin_prev_r, cin_prev_nxt, trg_prev_r, trg_prev_nxt;
    logic presc_tick, step, wrap, cin_pin, trg_pin, trg_fall;
    logic output_pin_enable, count_source_select;
    trc_word_t reload_word;

    trc_prescaler u_presc
    (
        .clk_sys(clk_sys),
        .rst(rst),
        .code(cfg_r[3:0]),
        .tick(presc_tick)
    );

    // Pin routing and step selection
    always_comb
    begin
        cin_pin = map_r ? pin_p61_in : pin_p10_in;
        trg_pin = map_r ? pin_p60_in : pin_p11_in;
        count_source_select = cfg_r[`TRC_CFG_SRC_BIT];
        output_pin_enable = cfg_r[`TRC_CFG_OUTEN_BIT];
        trg_fall = trg_prev_r & ~trg_pin;
        reload_word = {rcap_hi_r, rcap_lo_r};
        if (counter_mode)
            step = cin_prev_r & ~cin_pin;
        else if (count_source_select)
            step = prev_timer_overflow;
        else
            step = presc_tick;
        step = step & run_enable;
        wrap = step & (count_down ? (count_r == `TRC_RESET_WORD)
                                  : (count_r == `TRC_COUNT_MAX));
    end

    // Next-state for count, reload pair, config and output
    always_comb
    begin
        count_nxt = count_r;
        rcap_lo_nxt = rcap_lo_r;
        rcap_hi_nxt = rcap_hi_r;
        cfg_nxt = cfg_r;
        map_nxt = map_r;
        out_nxt = out_r;
        cin_prev_nxt = cin_pin;
        trg_prev_nxt = trg_pin;
        if (sfr_wr && sfr_addr == `TRC_ADDR_RCAP_LOW)
            rcap_lo_nxt = sfr_wdata;
        else if (sfr_wr && sfr_addr == `TRC_ADDR_RCAP_HIGH)
            rcap_hi_nxt = sfr_wdata;
        else if (sfr_wr && sfr_addr == `TRC_ADDR_CLK_CFG)
            cfg_nxt = 6'(sfr_wdata & `TRC_CFG_WR_MASK);
        else if (sfr_wr && sfr_addr == `TRC_ADDR_IO_MAP)
            map_nxt = sfr_wdata[`TRC_MAP_BIT];
        if (wrap)
            count_nxt = reload_word;
        else if (step)
            count_nxt = count_down ? 16'(count_r - 16'h0001) : 16'(count_r + 16'h0001);
        if (external_trigger_enable && trg_fall)
        begin
            if (reload_or_capture_select)
            begin
                rcap_lo_nxt = count_r[7:0];
                rcap_hi_nxt = count_r[15:8];
            end
            else
                count_nxt = reload_word;
        end
        if (!output_pin_enable)
            out_nxt = 1'b0;
        else if (toggle_output_select)
            out_nxt = wrap ? ~out_r : out_r;
        else
            out_nxt = wrap;
    end

    // Registers
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            count_r <= `TRC_RESET_WORD;
            rcap_lo_r <= `TRC_RESET_BYTE;
            rcap_hi_r <= `TRC_RESET_BYTE;
            cfg_r <= 6'h00;
            map_r <= 1'b0;
            out_r <= 1'b0;
            cin_prev_r <= 1'b0;
            trg_prev_r <= 1'b0;
        end
        else
        begin
            count_r <= count_nxt;
            rcap_lo_r <= rcap_lo_nxt;
            rcap_hi_r <= rcap_hi_nxt;
            cfg_r <= cfg_nxt;
            map_r <= map_nxt;
            out_r <= out_nxt;
            cin_prev_r <= cin_prev_nxt;
            trg_prev_r <= trg_prev_nxt;
        end
    end

    // Read mux
    always_comb
    begin
        if (sfr_addr == `TRC_ADDR_RCAP_LOW)
            sfr_rdata = rcap_lo_r;
        else if (sfr_addr == `TRC_ADDR_RCAP_HIGH)
            sfr_rdata = rcap_hi_r;
        else if (sfr_addr == `TRC_ADDR_CLK_CFG)
            sfr_rdata = {2'b00, cfg_r};
        else if (sfr_addr == `TRC_ADDR_IO_MAP)
            sfr_rdata = {5'b00000, map_r, 2'b00};
        else
            sfr_rdata = `TRC_RESET_BYTE;
    end

    // Outputs; overflow feeds the next timer and pulse width units
    assign overflow_pulse = wrap;
    assign trigger_event = external_trigger_enable & trg_fall;
    assign count_value = count_r;
    assign pin_p44_out = out_r & ~map_r;
    assign pin_p44_oe = output_pin_enable & ~map_r;
    assign pin_p12_out = out_r & map_r;
    assign pin_p12_oe = output_pin_enable & map_r;

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_reload;
        @(posedge clk_sys) disable iff (rst)
            (wrap && !(external_trigger_enable && trg_fall && reload_or_capture_select))
            |=> count_r == $past(reload_word);
    endproperty
    a_reload: assert property (p_reload) else $error("reload missed");

    property p_src;
        @(posedge clk_sys) disable iff (rst)
            (run_enable && !counter_mode && count_source_select && !prev_timer_overflow
             && !(external_trigger_enable && trg_fall)) |=> $stable(count_r);
    endproperty
    a_src: assert property (p_src) else $error("count moved without source");

    property p_off;
        @(posedge clk_sys) disable iff (rst) !output_pin_enable |=> !out_r;
    endproperty
    a_off: assert property (p_off) else $error("output not gated");

    // Pulse mode: pin follows the overflow one cycle later, one cycle wide
    property p_pulse;
        @(posedge clk_sys) disable iff (rst)
            (output_pin_enable && !toggle_output_select) |=> out_r == $past(wrap);
    endproperty
    a_pulse: assert property (p_pulse) else $error("pulse wrong");

    property p_toggle;
        @(posedge clk_sys) disable iff (rst)
            (output_pin_enable && toggle_output_select && wrap) |=> out_r != $past(out_r);
    endproperty
    a_toggle: assert property (p_toggle) else $error("no toggle");

    property p_map;
        @(posedge clk_sys) disable iff (rst) !(pin_p44_oe && pin_p12_oe);
    endproperty
    a_map: assert property (p_map) else $error("both pins driven");

    property p_capture;
        @(posedge clk_sys) disable iff (rst)
            (external_trigger_enable && trg_fall && reload_or_capture_select)
            |=> {rcap_hi_r, rcap_lo_r} == $past(count_r);
    endproperty
    a_capture: assert property (p_capture) else $error("capture missed");

    property p_wrap_dn;
        @(posedge clk_sys) disable iff (rst)
            (step && count_down && count_r == 16'h0000) |-> overflow_pulse;
    endproperty
    a_wrap_dn: assert property (p_wrap_dn) else $error("down overflow missed");

    property p_rsv;
        @(posedge clk_sys) disable iff (rst)
            (sfr_addr == `TRC_ADDR_CLK_CFG) |-> sfr_rdata[7:6] == 2'b00;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits nonzero");
endmodule // trc_timer2

// >>> testbench/trc_pin_model.sv
// Pin-side model that sources the count and trigger pins of the third timer.
// Assumes requests arrive from the bench as one-cycle pulses on clk_sys.
module trc_pin_model
(
    input wire logic map_sel,
    input wire logic cnt_fall,
    input wire logic trg_fall,
    output logic p10,
    output logic p11,
    output logic p61,
    output logic p60
);
    timeunit 1ns;
    timeprecision 1ns;
    // Pulled-up pins idle high; a request drops the mapped pin one cycle
    always_comb
    begin
        p10 = !(cnt_fall && !map_sel);
        p11 = !(trg_fall && !map_sel);
        p61 = !(cnt_fall && map_sel);
        p60 = !(trg_fall && map_sel);
    end
endmodule // trc_pin_model

// >>> testbench/trc_timer2_tb.sv
// Self-checking bench for the third timer reload, clock and output block.
// Assumes trc_timer2, trc_pkg and the pin model; clk_sys at 10 MHz.
module trc_timer2_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import trc_pkg::*;
    logic clk_sys, rst, sfr_wr, run_enable, count_down, counter_mode, prev_timer_overflow;
    logic toggle_output_select, external_trigger_enable, reload_or_capture_select;
    logic map_sel, cnt_fall, trg_fall, p10, p11, p61, p60, p44o, p44e, p12o, p12e, ovf, trg_ev;
    logic [7:0] sfr_addr, sfr_wdata;
    trc_byte_t sfr_rdata;
    trc_word_t count_value;
    int num_errors, samples_checked, n;
    logic v;

    trc_timer2 uut
    (
        .clk_sys(clk_sys), .rst(rst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
        .sfr_wr(sfr_wr), .sfr_rdata(sfr_rdata), .run_enable(run_enable),
        .count_down(count_down), .counter_mode(counter_mode),
        .toggle_output_select(toggle_output_select),
        .external_trigger_enable(external_trigger_enable),
        .reload_or_capture_select(reload_or_capture_select),
        .prev_timer_overflow(prev_timer_overflow), .pin_p10_in(p10), .pin_p11_in(p11),
        .pin_p61_in(p61), .pin_p60_in(p60), .pin_p44_out(p44o), .pin_p44_oe(p44e),
        .pin_p12_out(p12o), .pin_p12_oe(p12e), .count_value(count_value),
        .overflow_pulse(ovf), .trigger_event(trg_ev)
    );
    trc_pin_model pins
    (
        .map_sel(map_sel), .cnt_fall(cnt_fall), .trg_fall(trg_fall),
        .p10(p10), .p11(p11), .p61(p61), .p60(p60)
    );

    // Free-running system clock
    always #50 clk_sys = ~clk_sys;

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk_sys);
        sfr_wr <= 1'b0;
    endtask
    task rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        sfr_addr <= a;
        #1 chk(16'(sfr_rdata), 16'(e));
    endtask
    task wait_ovf;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            #1 n++;
        end
        while (ovf !== 1'b1 && n < 40000);
        if (ovf !== 1'b1)
            chk(16'(ovf), 16'h0001);
    endtask
    task trig;
        @(posedge clk_sys);
        trg_fall <= 1'b1;
        #1 chk(16'(trg_ev), 16'h0001);
        @(posedge clk_sys);
        trg_fall <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask
    task wrap_up;
        $display("Checks %0d, errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        clk_sys = 1'b0;
        rst = 1'b1;
        {sfr_wr, run_enable, count_down, counter_mode, prev_timer_overflow} = '0;
        {toggle_output_select, external_trigger_enable, reload_or_capture_select} = '0;
        {map_sel, cnt_fall, trg_fall, sfr_addr, sfr_wdata} = '0;
        num_errors = 0;
        samples_checked = 0;
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        rd_chk(8'h96, 8'h00);
        rd_chk(8'h9D, 8'h00);
        wr(8'h96, 8'hA5);
        wr(8'h97, 8'h5A);
        wr(8'h9D, 8'hFF);
        wr(8'hE1, 8'hFF);
        wr(8'h50, 8'h77);
        rd_chk(8'h96, 8'hA5);
        rd_chk(8'h97, 8'h5A);
        rd_chk(8'h9D, 8'h3F);
        rd_chk(8'hE1, 8'h04);
        rd_chk(8'h50, 8'h00);
        wr(8'hE1, 8'h00);
        // Down-count wrap loads the pair and pulses the output
        wr(8'h96, 8'h34);
        wr(8'h97, 8'h12);
        wr(8'h9D, 8'h10);
        @(posedge clk_sys);
        count_down <= 1'b1;
        run_enable <= 1'b1;
        wait_ovf();
        @(posedge clk_sys);
        #1 chk(count_value, 16'h1234);
        chk(16'(p44o), 16'h0001);
        chk(16'(p44e), 16'h0001);
        @(posedge clk_sys);
        #1 chk(16'(p44o), 16'h0000);
        wr(8'h96, 8'hFE);
        wr(8'h97, 8'hFF);
        wait_ovf();
        @(posedge clk_sys);
        count_down <= 1'b0;
        wait_ovf();
        @(posedge clk_sys);
        #1 chk(count_value, 16'hFFFE);
        // Toggle mode inverts and holds the level
        toggle_output_select <= 1'b1;
        wait_ovf();
        @(posedge clk_sys);
        #1 v = p44o;
        wait_ovf();
        @(posedge clk_sys);
        #1 chk(16'(p44o), 16'(!v));
        @(posedge clk_sys);
        #1 chk(16'(p44o), 16'(!v));
        toggle_output_select <= 1'b0;
        // Reload FFFF overflows every tick, so the gap is the divisor
        wr(8'h96, 8'hFF);
        for (int c = 0; c < 16; c++)
        begin
            if (c < 13 || c == 15)
            begin
                wr(8'h9D, 8'(c));
                wait_ovf();
                wait_ovf();
                chk(16'(n), 16'(1 << (c == 15 ? 14 : c)));
            end
        end
        // Chained source: only the preceding timer's pulses step the count
        wr(8'h9D, 8'h20);
        n = 0;
        for (int i = 0; i < 12; i++)
        begin
            @(posedge clk_sys);
            prev_timer_overflow <= (i % 4 == 0);
            #1 n += int'(ovf === 1'b1);
        end
        chk(16'(n), 16'h0003);
        // Alternate pin set, then trigger reload and capture
        @(posedge clk_sys);
        run_enable <= 1'b0;
        map_sel <= 1'b1;
        wr(8'hE1, 8'h04);
        wr(8'h9D, 8'h10);
        #1 chk(16'(p12e), 16'h0001);
        chk(16'(p44e), 16'h0000);
        external_trigger_enable <= 1'b1;
        wr(8'h96, 8'h55);
        wr(8'h97, 8'hAA);
        trig();
        #1 chk(count_value, 16'hAA55);
        wr(8'h96, 8'h00);
        wr(8'h97, 8'h00);
        reload_or_capture_select <= 1'b1;
        trig();
        rd_chk(8'h96, 8'h55);
        rd_chk(8'h97, 8'hAA);
        // Trigger reload to FFFF, then run: overflow pulses the alternate pin
        wr(8'h96, 8'hFF);
        wr(8'h97, 8'hFF);
        reload_or_capture_select <= 1'b0;
        trig();
        run_enable <= 1'b1;
        wait_ovf();
        @(posedge clk_sys);
        #1 chk(16'(p12o), 16'h0001);
        chk(16'(p44o), 16'h0000);
        // Counter mode: each falling edge on the count pin is one step
        counter_mode <= 1'b1;
        wr(8'h96, 8'h00);
        wr(8'h97, 8'h00);
        repeat (3)
        begin
            @(posedge clk_sys);
            cnt_fall <= 1'b1;
            @(posedge clk_sys);
            cnt_fall <= 1'b0;
        end
        repeat (2) @(posedge clk_sys);
        #1 chk(count_value, 16'h0002);
        wrap_up();
    end

    // Watchdog cuts a hang short
    initial
    begin
        #8000000;
        num_errors++;
        wrap_up();
    end
endmodule // trc_timer2_tb
